// *** src/efrl_top.v ***
// Overview of operation
// - Lock bit 4 hides public key fuse bytes 128 to 191 when set.
// - Lock bit 3 hides user fuse bytes 192 to 511 when set.
// - Lock bit 2 hides private key fuse bytes 0 to 31 when set.
// - Lock bit 1 hides maker fuse bytes 32 to 127 when set.
// - Each lock bit accepts one write, then is read-only until system reset.
// - Enabled debug port makes every protected region inaccessible.
// - Reads of an inaccessible region return one fixed constant byte.
// - System reset clears all lock bits and makes them writable again.
// - Four-bit watchdog count, cleared at power-on, kept across watchdog reset.
// - Debug port works only when enabled; else debug reset pin is ignored.
//
// The Wishbone interface to the registers was decided locally.
`include "efrl_regs.vh"
`default_nettype none

module efrl_top (
    // Clock and power-on reset
    input  wire        mclk_in,
    input  wire        reset_n_in,
    // System reset pulse, also raised by a watchdog reset
    input  wire        system_reset_in,
    // Wishbone slave
    input  wire        wb_cyc_in,
    input  wire        wb_stb_in,
    input  wire        wb_we_in,
    input  wire [7:0]  wb_adr_in,
    input  wire [3:0]  wb_sel_in,
    input  wire [31:0] wb_dat_in,
    output reg  [31:0] wb_dat_out,
    output reg         wb_ack_out,
    // Debug enable bit from the debug control register
    input  wire        debug_enable_in,
    // Debug reset pin, active low, asynchronous
    input  wire        debug_rst_n_pin_in,
    output reg         debug_port_active_out,
    // Fuse read path
    input  wire        fuse_rd_valid_in,
    input  wire [8:0]  fuse_rd_addr_in,
    input  wire [7:0]  fuse_rd_data_in,
    output reg         fuse_rd_valid_out,
    output reg  [7:0]  fuse_rd_data_out,
    output reg         fuse_rd_blocked_out,
    // Lock and count state
    output reg  [3:0]  region_lock_out,
    output reg  [3:0]  watchdog_fire_count_out
);

    // Lock bits, index 0..3 maps to register bits 1..4
    reg  [3:0]  region_lock;
    reg  [3:0]  lock_written;
    reg  [3:0]  watchdog_fire_count;
    reg  [31:0] next_rd_data;
    wire        debug_rst_n_sync;
    wire        gate_blocked;
    wire [3:0]  lock_reset_val;
    wire        bus_req;
    wire        wr_req;
    wire        sel_lock;
    wire        sel_wdcnt;
    wire        sel_status;
    wire        lane0_wr;
    wire [3:0]  region_status;
    wire        maker_region_lock;

    assign bus_req    = wb_cyc_in && wb_stb_in && !wb_ack_out;
    assign wr_req     = bus_req && wb_we_in;
    // Byte lanes 1:0 of the address are ignored, so compare on word boundaries
    assign sel_lock   = ({wb_adr_in[7:2], 2'h0} == `EFRL_LOCK_OFFSET);
    assign sel_wdcnt  = ({wb_adr_in[7:2], 2'h0} == `EFRL_WDCNT_OFFSET);
    assign sel_status = ({wb_adr_in[7:2], 2'h0} == `EFRL_STATUS_OFFSET);
    assign lock_reset_val = `EFRL_LOCK_RESET;
    // All writable fields sit in byte lane 0
    assign lane0_wr   = wr_req && wb_sel_in[0];

    assign maker_region_lock = region_lock[0];

    // Pin level is resynchronised before any logic looks at it
    efrl_sync u_dbg_sync (
        .mclk_in    (mclk_in),
        .reset_n_in (reset_n_in),
        .async_in   (debug_rst_n_pin_in),
        .sync_out   (debug_rst_n_sync)
    );

    efrl_fuse_gate u_gate (
        .addr_in         (fuse_rd_addr_in),
        .lock_in         (region_lock),
        .debug_enable_in (debug_enable_in),
        .region_hit_out  (),
        .blocked_out     (gate_blocked)
    );

    // Per-region accessibility as seen by the fuse path right now
    assign region_status = debug_enable_in ? 4'hf : region_lock;

    // Write-once lock bits. The written flag is separate from the value so
    // that writing a zero still consumes the single allowed write.
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_lock
            always @(posedge mclk_in or negedge reset_n_in) begin
                if (!reset_n_in) begin
                    region_lock[gi]  <= 1'b0;
                    lock_written[gi] <= 1'b0;
                end else if (system_reset_in) begin
                    region_lock[gi]  <= lock_reset_val[gi];
                    lock_written[gi] <= 1'b0;
                end else if (lane0_wr && sel_lock && !lock_written[gi]) begin
                    region_lock[gi]  <= wb_dat_in[`EFRL_LOCK_LSB + gi];
                    lock_written[gi] <= 1'b1;
                end
            end
        end
    endgenerate

    // Only power-on clears the count; system and watchdog resets leave it
    always @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            watchdog_fire_count <= `EFRL_WDCNT_RESET;
        end else if (lane0_wr && sel_wdcnt) begin
            // Firmware stores the firing tally here before the image runs
            watchdog_fire_count <= wb_dat_in[`EFRL_WDCNT_MSB:`EFRL_WDCNT_LSB];
        end
    end

    // Read mux; unmapped offsets and unused bits read zero
    always @* begin
        next_rd_data = 32'h0000_0000;
        if (sel_lock) begin
            next_rd_data[`EFRL_LOCK_MSB:`EFRL_LOCK_LSB] = region_lock;
        end else if (sel_wdcnt) begin
            next_rd_data[`EFRL_WDCNT_MSB:`EFRL_WDCNT_LSB] = watchdog_fire_count;
        end else if (sel_status) begin
            next_rd_data[`EFRL_STAT_BLK_MSB:`EFRL_STAT_BLK_LSB] = region_status;
            next_rd_data[`EFRL_STAT_DBG_BIT] = debug_port_active_out;
            next_rd_data[`EFRL_STAT_WR_MSB:`EFRL_STAT_WR_LSB] = lock_written;
        end
    end

    // Single-wait-state slave: ack one cycle after the request, then drop
    always @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            wb_ack_out <= 1'b0;
            wb_dat_out <= 32'h0000_0000;
        end else begin
            wb_ack_out <= bus_req;
            if (bus_req && !wb_we_in) begin
                wb_dat_out <= next_rd_data;
            end
        end
    end

    // Debug pin has no effect at all while the port is disabled
    always @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            debug_port_active_out <= 1'b0;
        end else begin
            debug_port_active_out <= debug_enable_in && debug_rst_n_sync;
        end
    end

    // Fuse read path, one cycle of latency; locked bytes never leave here
    always @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            fuse_rd_valid_out   <= 1'b0;
            fuse_rd_data_out    <= `EFRL_LOCKED_FILL;
            fuse_rd_blocked_out <= 1'b0;
        end else begin
            fuse_rd_valid_out   <= fuse_rd_valid_in;
            fuse_rd_blocked_out <= fuse_rd_valid_in && gate_blocked;
            if (fuse_rd_valid_in && gate_blocked) begin
                fuse_rd_data_out <= `EFRL_LOCKED_FILL;
            end else if (fuse_rd_valid_in) begin
                fuse_rd_data_out <= fuse_rd_data_in;
            end
        end
    end

    // State mirrors for the rest of the chip
    always @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            region_lock_out         <= 4'h0;
            watchdog_fire_count_out <= 4'h0;
        end else begin
            region_lock_out         <= {region_lock[3:1], maker_region_lock};
            watchdog_fire_count_out <= watchdog_fire_count;
        end
    end

endmodule

`default_nettype wire

// *** src/efrl_regs.vh ***
`ifndef EFRL_REGS_VH
`define EFRL_REGS_VH

// Register byte offsets
`define EFRL_LOCK_OFFSET      8'h24
`define EFRL_WDCNT_OFFSET     8'h28
`define EFRL_STATUS_OFFSET    8'h30

// Lock register fields
`define EFRL_LOCK_MAKER_BIT   1
`define EFRL_LOCK_PRIV_BIT    2
`define EFRL_LOCK_USER_BIT    3
`define EFRL_LOCK_PUB_BIT     4
`define EFRL_LOCK_LSB         1
`define EFRL_LOCK_MSB         4
`define EFRL_LOCK_RESET       4'h0

// Watchdog count field
`define EFRL_WDCNT_LSB        0
`define EFRL_WDCNT_MSB        3
`define EFRL_WDCNT_RESET      4'h0

// Status register fields
`define EFRL_STAT_BLK_LSB     0
`define EFRL_STAT_BLK_MSB     3
`define EFRL_STAT_DBG_BIT     4
`define EFRL_STAT_WR_LSB      8
`define EFRL_STAT_WR_MSB      11

// Fuse region bounds, byte addresses inclusive
`define EFRL_PRIV_FIRST       9'h000
`define EFRL_PRIV_LAST        9'h01f
`define EFRL_MAKER_FIRST      9'h020
`define EFRL_MAKER_LAST       9'h07f
`define EFRL_PUB_FIRST        9'h080
`define EFRL_PUB_LAST         9'h0bf
`define EFRL_USER_FIRST       9'h0c0
`define EFRL_USER_LAST        9'h1ff

// Value returned for every byte of a locked region
`define EFRL_LOCKED_FILL      8'h00

`endif

// *** src/efrl_sync.v ***
`default_nettype none

// Two-stage synchroniser for a single asynchronous level
module efrl_sync (
    // Clock and reset
    input  wire mclk_in,
    input  wire reset_n_in,
    // Level
    input  wire async_in,
    output reg  sync_out
);

    reg meta;

    always @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            meta     <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end

endmodule

`default_nettype wire

// *** src/efrl_fuse_gate.v ***
`include "efrl_regs.vh"
`default_nettype none

// Decides whether a fuse byte address lies in a region that is currently
// inaccessible. Pure combinational; the caller registers the result.
module efrl_fuse_gate (
    // Fuse address
    input  wire [8:0] addr_in,
    // Lock state, indexed as lock register bits 4:1
    input  wire [3:0] lock_in,
    input  wire       debug_enable_in,
    // Result
    output reg  [3:0] region_hit_out,
    output reg        blocked_out
);

    always @* begin
        region_hit_out = 4'h0;
        // Index 0 = maker, 1 = private, 2 = user, 3 = public
        region_hit_out[0] = (addr_in >= `EFRL_MAKER_FIRST) &&
                            (addr_in <= `EFRL_MAKER_LAST);
        region_hit_out[1] = (addr_in <= `EFRL_PRIV_LAST);
        region_hit_out[2] = (addr_in >= `EFRL_USER_FIRST);
        region_hit_out[3] = (addr_in >= `EFRL_PUB_FIRST) &&
                            (addr_in <= `EFRL_PUB_LAST);
        // Debug access overrides every lock setting
        blocked_out = debug_enable_in ||
                      (|(region_hit_out & lock_in));
    end

endmodule

`default_nettype wire

// *** verification/efrl_chk_sva.sv ***
`include "efrl_regs.vh"
`default_nettype none
module efrl_chk (
    // Clock and resets
    input wire logic       mclk_in,
    input wire logic       reset_n_in,
    input wire logic       system_reset_in,
    // Bus and fuse path
    input wire logic       wb_cyc_in,
    input wire logic       wb_stb_in,
    input wire logic       wb_ack_out,
    input wire logic       debug_enable_in,
    input wire logic       fuse_rd_valid_in,
    input wire logic [8:0] fuse_rd_addr_in,
    input wire logic [7:0] fuse_rd_data_in,
    input wire logic       fuse_rd_valid_out,
    input wire logic [7:0] fuse_rd_data_out,
    input wire logic       fuse_rd_blocked_out,
    input wire logic [3:0] region_lock_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       sr_q;
    wire  [8:0] a = fuse_rd_addr_in;
    // The lock mirror may trail the live lock by a cycle around resets and writes
    wire        quiet = !system_reset_in && !sr_q && !wb_ack_out;
    always_ff @(posedge mclk_in or negedge reset_n_in)
        if (!reset_n_in) sr_q <= 1'h0;
        else sr_q <= system_reset_in;
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!reset_n_in);
    sequence s_take; wb_cyc_in && wb_stb_in && !wb_ack_out; endsequence
    sequence s_ack; wb_ack_out ##1 !wb_ack_out; endsequence
    sequence s_hid; fuse_rd_blocked_out && fuse_rd_data_out == `EFRL_LOCKED_FILL; endsequence
    property p_hide(lk, lo, hi);
        fuse_rd_valid_in && lk && quiet && a >= lo && a <= hi |=> s_hid;
    endproperty
    property p_open;
        fuse_rd_valid_in && !debug_enable_in && region_lock_out == 4'h0 && quiet
            |=> !fuse_rd_blocked_out && fuse_rd_data_out == $past(fuse_rd_data_in);
    endproperty
    AST_ACK: assert property (s_take |=> s_ack) else $error("bus ack timing wrong");
    AST_FUSE_LAT: assert property (1'h1 |=> fuse_rd_valid_out == $past(fuse_rd_valid_in))
        else $error("fuse valid latency wrong");
    AST_PUB: assert property (p_hide(region_lock_out[3], 9'h080, 9'h0bf))
        else $error("public key byte not hidden");
    AST_USER: assert property (p_hide(region_lock_out[2], 9'h0c0, 9'h1ff))
        else $error("user byte not hidden");
    AST_PRIV: assert property (p_hide(region_lock_out[1], 9'h000, 9'h01f))
        else $error("private key byte not hidden");
    AST_MAKER: assert property (p_hide(region_lock_out[0], 9'h020, 9'h07f))
        else $error("maker byte not hidden");
    AST_DEBUG: assert property (fuse_rd_valid_in && debug_enable_in |=> s_hid)
        else $error("byte not hidden under debug");
    AST_OPEN: assert property (p_open)
        else $error("open byte altered");
    AST_SYSRST: assert property (system_reset_in |-> ##[1:2] region_lock_out == 4'h0)
        else $error("lock not cleared by system reset");
    AST_HOLD: assert property (!system_reset_in && !sr_q |=>
        (region_lock_out & $past(region_lock_out)) == $past(region_lock_out))
        else $error("lock bit cleared without reset");
endmodule
bind efrl_top efrl_chk u_chk (.*);
`default_nettype wire

// *** verification/efuse_region_lock_and_watchdog_fire_count_test.sv ***
`include "efrl_regs.vh"
`default_nettype none
module efuse_region_lock_and_watchdog_fire_count_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk_in, reset_n_in, system_reset_in, wb_cyc_in, wb_stb_in, wb_we_in;
    logic [7:0]  wb_adr_in, fuse_rd_data_in, fuse_rd_data_out;
    logic [3:0]  wb_sel_in, region_lock_out, watchdog_fire_count_out;
    logic [31:0] wb_dat_in, wb_dat_out, rd;
    logic        wb_ack_out, debug_enable_in, debug_rst_n_pin_in, debug_port_active_out;
    logic        fuse_rd_valid_in, fuse_rd_valid_out, fuse_rd_blocked_out;
    logic [8:0]  fuse_rd_addr_in;
    int          num_errors, num_checks, cycles;
    efrl_top u_dut (.*);
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            num_errors++;
            $display("unexpected %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic bus(input logic we, input logic [7:0] ad, input logic [31:0] d,
                       input logic [3:0] s);
        wb_cyc_in <= 1'h1;
        wb_stb_in <= 1'h1;
        wb_we_in  <= we;
        wb_adr_in <= ad;
        wb_dat_in <= d;
        wb_sel_in <= s;
        @(posedge mclk_in iff wb_ack_out);
        rd = wb_dat_out;
        wb_cyc_in <= 1'h0;
        wb_stb_in <= 1'h0;
        @(posedge mclk_in);
    endtask
    task automatic rdq(input string n, input logic [7:0] ad, input logic [31:0] e);
        bus(1'h0, ad, 32'h0, 4'hf);
        chk(n, e, rd);
    endtask
    // Region boundary bytes; lock index per pair: private, maker, public, user
    task automatic sweep(input logic [3:0] lk);
        logic [8:0] ad[8] = '{9'h0, 9'h1f, 9'h20, 9'h7f, 9'h80, 9'hbf, 9'hc0, 9'h1ff};
        int         rg[4] = '{1, 0, 3, 2};
        logic       b;
        logic [7:0] x;
        foreach (ad[i]) begin
            // Debug enable is folded into lk by the caller
            b = lk[rg[i/2]];
            x = b ? `EFRL_LOCKED_FILL : ad[i][7:0] ^ 8'h5a;
            fuse_rd_valid_in <= 1'h1;
            fuse_rd_addr_in  <= ad[i];
            fuse_rd_data_in  <= ad[i][7:0] ^ 8'h5a;
            @(posedge mclk_in);
            fuse_rd_valid_in <= 1'h0;
            // Look between edges, where the answer has settled
            @(negedge mclk_in);
            chk("fuse", {22'h0, b, x, 1'h1},
                {22'h0, fuse_rd_blocked_out, fuse_rd_data_out, fuse_rd_valid_out});
            @(posedge mclk_in);
        end
    endtask
    initial begin
        mclk_in = 1'h0;
        forever #2 mclk_in = ~mclk_in;
    end
    always @(posedge mclk_in) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            tally_and_finish();
        end
    end
    initial begin
        {reset_n_in, system_reset_in, wb_cyc_in, wb_stb_in, wb_we_in} = 5'h0;
        {debug_enable_in, debug_rst_n_pin_in, fuse_rd_valid_in} = 3'h0;
        {wb_adr_in, wb_dat_in, wb_sel_in, fuse_rd_addr_in, fuse_rd_data_in} = 61'h0;
        repeat (6) @(posedge mclk_in);
        reset_n_in <= 1'h1;
        rdq("lock", `EFRL_LOCK_OFFSET, 32'h0);
        rdq("count", `EFRL_WDCNT_OFFSET, 32'h0);
        bus(1'h1, 8'h3c, 32'hffffffff, 4'hf);
        rdq("unmapped", 8'h3c, 32'h0);
        sweep(4'h0);
        bus(1'h1, `EFRL_WDCNT_OFFSET, 32'hfffffff5, 4'he);
        rdq("count", `EFRL_WDCNT_OFFSET, 32'h0);
        bus(1'h1, `EFRL_WDCNT_OFFSET, 32'hfffffff5, 4'hf);
        rdq("count", `EFRL_WDCNT_OFFSET, 32'h5);
        bus(1'h1, `EFRL_LOCK_OFFSET, 32'hffffffed, 4'hf);
        rdq("lock", `EFRL_LOCK_OFFSET, 32'hc);
        bus(1'h1, `EFRL_LOCK_OFFSET, 32'h1e, 4'hf);
        rdq("lock", `EFRL_LOCK_OFFSET, 32'hc);
        chk("mirror", 32'h6, {28'h0, region_lock_out});
        sweep(4'h6);
        debug_enable_in <= 1'h1;
        sweep(4'hf);
        debug_enable_in <= 1'h0;
        system_reset_in <= 1'h1;
        @(posedge mclk_in);
        system_reset_in <= 1'h0;
        @(posedge mclk_in);
        rdq("lock", `EFRL_LOCK_OFFSET, 32'h0);
        rdq("count", `EFRL_WDCNT_OFFSET, 32'h5);
        chk("count port", 32'h5, {28'h0, watchdog_fire_count_out});
        bus(1'h1, `EFRL_LOCK_OFFSET, 32'h12, 4'hf);
        rdq("lock", `EFRL_LOCK_OFFSET, 32'h12);
        rdq("status", `EFRL_STATUS_OFFSET, 32'hf09);
        sweep(4'h9);
        reset_n_in <= 1'h0;
        repeat (2) @(posedge mclk_in);
        reset_n_in <= 1'h1;
        rdq("count", `EFRL_WDCNT_OFFSET, 32'h0);
        debug_enable_in <= 1'h1;
        repeat (5) @(posedge mclk_in);
        chk("debug", 32'h0, {31'h0, debug_port_active_out});
        debug_rst_n_pin_in <= 1'h1;
        repeat (5) @(posedge mclk_in);
        chk("debug", 32'h1, {31'h0, debug_port_active_out});
        rdq("status", `EFRL_STATUS_OFFSET, 32'h1f);
        debug_enable_in <= 1'h0;
        repeat (5) @(posedge mclk_in);
        chk("debug", 32'h0, {31'h0, debug_port_active_out});
        tally_and_finish();
    end
endmodule
`default_nettype wire
